// [test/eth_transmit_request_logic_tb_top.sv]
// Purpose: bid, fill and send checks through the register port
// Assumes: memory-space offsets; line model answers on the line side
// Notes:   line failure input stays low; collisions are pulsed by the bench
`default_nettype none
`timescale 1ns/100ps
module eth_transmit_request_logic_tb_top;
   import eth_tx_pkg::*;
   logic        clk_sys;
   logic        reset;
   logic        lineReady;
   logic        lineOk;
   logic        lineCollision;
   logic        slow;
   logic        irqOut;
   logic        sawCheck;
   logic [15:0] hostRdData;
   logic [15:0] rv;
   logic [15:0] byteSum;
   hostReq_s    hostReq;
   lineTx_s     lineTx;
   int          nBytes;
   int          nFrames;
   int          n_errors;
   int          cmp_count;
   eth_transmit_request_logic uut (.clk_sys(clk_sys), .reset(reset), .hostReq(hostReq),
      .hostRdData(hostRdData), .irqOut(irqOut), .lineTx(lineTx), .lineReady(lineReady),
      .lineCollision(lineCollision), .lineOk(lineOk), .lineFail(1'b0));
   line_model line (.clk_sys(clk_sys), .reset(reset), .lineTx(lineTx), .slow(slow),
      .lineReady(lineReady), .nBytes(nBytes), .nFrames(nFrames), .byteSum(byteSum),
      .sawCheck(sawCheck));
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic report_and_stop();
      $display("errors %0d of %0d compares", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      hostReq <= '{addr: a, wrData: d, write: 1'b1, read: 1'b0};
      @(negedge clk_sys);
      hostReq.write <= 1'b0;
   endtask
   // data is registered on the same edge that samples the read
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      @(negedge clk_sys);
      hostReq <= '{addr: a, wrData: 16'h0000, write: 1'b0, read: 1'b1};
      @(negedge clk_sys);
      hostReq.read <= 1'b0;
      @(negedge clk_sys);
      d = hostRdData;
   endtask
   task automatic bid(input logic [15:0] cmd, input logic [15:0] len);
      wr(ADDR_TX_CMD, cmd);
      wr(ADDR_TX_LEN, len);
      rd(ADDR_BUS_STAT, rv);
      rv = rv & 16'h0180;
   endtask
   // word i carries bytes 2i and 2i+1, low byte first
   task automatic fill(input int from, input int n);
      for (int i = from; i < from + n; i++)
         wr(ADDR_FRAME_WIN, {8'(2 * i + 1), 8'(2 * i)});
   endtask
   function automatic logic [15:0] sumOf(input int len);
      logic [15:0] s;
      s = 16'h0000;
      for (int b = 0; b < len; b++)
         s = s + {8'h00, 8'(b)};
      return s;
   endfunction
   task automatic waitFrame(input int f, input int n, input int len, input logic c);
      int k;
      for (k = 0; k < 5000 && nFrames < f; k++)
         @(negedge clk_sys);
      if (nFrames < f)
      begin
         n_errors++;
         $display("BAD %0t frame wait timed out", $time);
         report_and_stop();
      end
      chk(16'(nBytes), 16'(n));
      chk(byteSum, sumOf(len));
      chk({15'h0000, sawCheck}, {15'h0000, c});
   endtask
   task automatic done();
      @(negedge clk_sys);
      lineOk <= 1'b1;
      @(negedge clk_sys);
      lineOk <= 1'b0;
      @(negedge clk_sys);
      chk({15'h0000, irqOut}, 16'h0001);
      rd(ADDR_TX_EVENT, rv);
      chk(rv & 16'h0100, 16'h0100);
   endtask
   // one-cycle collision pulse while the frame is still held
   task automatic collide();
      @(negedge clk_sys);
      lineCollision <= 1'b1;
      @(negedge clk_sys);
      lineCollision <= 1'b0;
   endtask
   initial
   begin
      hostReq = '0;
      lineOk = 1'b0;
      lineCollision = 1'b0;
      slow = 1'b0;
      n_errors = 0;
      cmp_count = 0;
      reset = 1'b1;
      repeat (5) @(negedge clk_sys);
      reset = 1'b0;
      rd(ADDR_TX_CMD, rv);
      chk(rv, REG_RESET);
      chk({15'h0000, irqOut}, 16'h0000);
      wr(ADDR_TX_CFG, 16'h0100);
      bid(16'h0000, 16'd2);
      chk(rv, 16'h0080);
      bid(16'h0000, 16'd1515);
      chk(rv, 16'h0080);
      bid(16'h1000, 16'd1519);
      chk(rv, 16'h0080);
      // legal only because the check value is inhibited
      bid(16'h10C0, 16'd1515);
      chk(rv, 16'h0100);
      fill(0, 2);
      wr(ADDR_TX_CMD, 16'h0100);
      rd(ADDR_TX_CMD, rv);
      chk(rv, 16'h0100);
      repeat (20) @(negedge clk_sys);
      chk({15'h0000, lineTx.valid}, 16'h0000);
      slow = 1'b1;
      bid(16'h0000, 16'd6);
      chk(rv, 16'h0100);
      fill(0, 3);
      waitFrame(1, 60, 6, 1'b1);
      done();
      chk({15'h0000, irqOut}, 16'h0000);
      slow = 1'b0;
      fill(0, 2);
      bid(16'h30C0, 16'd6);
      chk(rv, 16'h0100);
      fill(0, 2);
      repeat (20) @(negedge clk_sys);
      chk({15'h0000, lineTx.valid}, 16'h0000);
      fill(2, 1);
      waitFrame(2, 6, 6, 1'b0);
      done();
      wr(ADDR_BUF_CFG, 16'h0100);
      bid(16'h2000, 16'd8);
      chk(rv, 16'h0100);
      fill(0, 4);
      waitFrame(3, 60, 8, 1'b1);
      bid(16'h0000, 16'd6);
      chk(rv, 16'h0000);
      fill(0, 3);
      done();
      rd(ADDR_ISQ, rv);
      chk(rv & 16'h0100, 16'h0100);
      fill(0, 3);
      waitFrame(4, 60, 6, 1'b1);
      done();
      wr(ADDR_BUF_CFG, 16'h0000);
      for (int c = 1; c < 3; c++)
      begin
         int th;
         th = (c == 1) ? 381 : 1021;
         bid(16'(c << CMD_START_LSB), 16'(th + 1));
         chk(rv, 16'h0100);
         fill(0, th / 2);
         repeat (10) @(negedge clk_sys);
         chk({15'h0000, lineTx.valid}, 16'h0000);
         fill(th / 2, 1);
         waitFrame(3 + c + 1, th + 1, th + 1, 1'b1);
         done();
      end
      // collision with retries allowed: the whole frame goes out again
      bid(16'h0000, 16'd6);
      chk(rv, 16'h0100);
      fill(0, 3);
      waitFrame(7, 60, 6, 1'b1);
      collide();
      waitFrame(8, 60, 6, 1'b1);
      done();
      // single attempt: the collision drops the frame, no resend, no success
      bid(16'h0200, 16'd6);
      chk(rv, 16'h0100);
      fill(0, 3);
      waitFrame(9, 60, 6, 1'b1);
      collide();
      repeat (200) @(negedge clk_sys);
      chk(16'(nFrames), 16'd9);
      rd(ADDR_TX_EVENT, rv);
      chk(rv & 16'h0100, 16'h0000);
      // a length without a fresh command must not bid
      wr(ADDR_TX_LEN, 16'd6);
      rd(ADDR_BUS_STAT, rv);
      chk(rv & 16'h0180, 16'h0000);
      report_and_stop();
   end
endmodule
`default_nettype wire

// [test/line_model.sv]
// Purpose: line side stand-in that takes frame bytes from the block
// Assumes: one byte per accepted cycle; ready may be slowed to every other cycle
// Notes:   keeps a byte sum, not a copy, to stay small
`default_nettype none
`timescale 1ns/100ps
module line_model
   import eth_tx_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                reset,
   input  wire eth_tx_pkg::lineTx_s lineTx,
   input  wire logic                slow,
   output logic                     lineReady,
   output int                       nBytes,
   output int                       nFrames,
   output logic [15:0]              byteSum,
   output logic                     sawCheck
);
   logic tgl;
   wire  take = lineTx.valid & lineReady;
   initial tgl = 1'b0;
   // slow mode stalls every other cycle
   always @(negedge clk_sys) tgl <= ~tgl;
   assign lineReady = slow ? tgl : 1'b1;
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         nBytes   <= 0;
         nFrames  <= 0;
         byteSum  <= 16'h0000;
         sawCheck <= 1'b0;
      end
      else if (take)
      begin
         nBytes   <= lineTx.first ? 1 : nBytes + 1;
         byteSum  <= (lineTx.first ? 16'h0000 : byteSum) + {8'h00, lineTx.data};
         sawCheck <= lineTx.appendCheck;
         if (lineTx.last)
            nFrames <= nFrames + 1;
      end
   end
endmodule
`default_nettype wire

// [verilog/eth_transmit_request_logic.sv]
// Purpose: transmit bid, buffer commit and frame streaming for the MAC
// Assumes: line side signals come from logic on clk_sys
// Notes:   one frame of buffer; a new bid waits while a frame is held
// Operation
// RULE_01: host writes command, then length, then reads bus status.
// RULE_02: every frame needs a fresh command write; partial bids do nothing.
// RULE_03: command register reads back the last written value.
// RULE_04: start threshold picks 5, 381, 1021 bytes or whole frame.
// RULE_05: discard bit throws away all buffered frame data.
// RULE_06: single-attempt bit stops retry after a collision.
// RULE_07: check value inhibit suppresses the appended check value.
// RULE_08: pad disable stops padding of short frames; here padding follows check value inhibit alone and pad disable has no effect.
// RULE_09: both clear, short frames padded to 64 bytes with check.
// RULE_10: inhibit only, frames under 60 bytes go out as runts.
// RULE_11: pad disable only, pad to 60 bytes excluding check value.
// RULE_12: both set, runts below 64; never send under 3 bytes.
// RULE_13: bad length drops the bid and sets bid error.
// RULE_14: ready-now set when the frame can be accepted.
// RULE_15: host keeps buffer-ready enable clear for polling, set otherwise.
// RULE_16: with enable set, buffer-ready flag raised and interrupt once free.
// RULE_17: I/O-space host reaches bus status via pointer and data port.
// RULE_18: memory-space host reads bus status directly.
// RULE_19: host streams the frame by word writes to the frame window.
// RULE_20: success sets transmit-success flag; interrupt if enabled.
// RULE_21: enable clear, ready-now also reports space freed later.
// RULE_22: older silicon prefers threshold code 01.
// RULE_23: commit only after good bid and a set ready flag was read.
// RULE_24: send data once threshold met, then pad and check value.
// RULE_25: frame writes without committed space are ignored.
`default_nettype none
`timescale 1ns/100ps
module eth_transmit_request_logic (
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   input  wire eth_tx_pkg::hostReq_s hostReq,
   output logic [15:0]               hostRdData,
   output logic                      irqOut,
   output eth_tx_pkg::lineTx_s       lineTx,
   input  wire logic                 lineReady,
   input  wire logic                 lineCollision,
   input  wire logic                 lineOk,
   input  wire logic                 lineFail
);
   import eth_tx_pkg::*;

   logic [15:0] txCommand;
   logic [15:0] transmit_configuration;
   logic [15:0] buffer_configuration;
   logic        reqPending;
   logic        cmdFresh;
   logic        bidError;
   logic        readyNow;
   logic        bufReady;
   logic        txOkFlag;
   txState_e    state;
   txState_e    next_state;
   logic [10:0] actLength;
   logic [10:0] actPadTo;
   logic [10:0] bidPadTo;
   logic [10:0] bidLength;
   logic [1:0]  actStart;
   logic        actNoCheck;
   logic        actOneAttempt;
   logic [10:0] wrBytes;
   logic [10:0] sendIdx;
   logic        lengthOk;
   logic [10:0] padTo;
   logic [7:0]  storeByte;

   // register decode
   wire logic wrCmd   = hostReq.write && hostReq.addr == ADDR_TX_CMD;
   wire logic wrLen   = hostReq.write && hostReq.addr == ADDR_TX_LEN;
   wire logic wrTxCfg = hostReq.write && hostReq.addr == ADDR_TX_CFG;
   wire logic wrBufCf = hostReq.write && hostReq.addr == ADDR_BUF_CFG;
   wire logic wrWin   = hostReq.write && hostReq.addr == ADDR_FRAME_WIN;
   wire logic rdBus   = hostReq.read && hostReq.addr == ADDR_BUS_STAT;
   wire logic rdIsq   = hostReq.read && hostReq.addr == ADDR_ISQ;
   wire logic rdEvt   = hostReq.read && hostReq.addr == ADDR_TX_EVENT;
   wire logic rdCmd   = hostReq.read && hostReq.addr == ADDR_TX_CMD;

   tx_length_check u_len (
      .length   (hostReq.wrData),
      .noCheck  (txCommand[CMD_NO_CHECK]),
      .padDis   (txCommand[CMD_PAD_DIS]),
      .lengthOk (lengthOk),
      .padTo    (padTo)
   );

   // bid bookkeeping; a length without a fresh command is ignored
   wire logic spaceFree   = state == S_IDLE;
   wire logic bufReadyIE  = buffer_configuration[BUF_READY_IE];
   wire logic discard     = wrCmd && hostReq.wrData[CMD_DISCARD]; // RULE_05
   wire logic lenOkWrite  = wrLen && cmdFresh && lengthOk; // RULE_02
   wire logic lenBadWrite = wrLen && cmdFresh && !lengthOk; // RULE_13
   wire logic commit      = spaceFree && reqPending &&
                            ((rdBus && readyNow) || (rdIsq && bufReady)); // RULE_23
   wire logic readySet    = spaceFree && !commit &&
                            (lenOkWrite || (reqPending && !bufReadyIE)); // RULE_14 RULE_21
   wire logic bufRdySet   = spaceFree && reqPending && bufReadyIE &&
                            !readyNow && !commit; // RULE_16
   wire logic okSet       = state == S_RESULT && lineOk && !discard; // RULE_20

   // streaming control
   wire logic [10:0] thresh   = actStart == 2'h0 ? THRESH_0 :
                                actStart == 2'h1 ? THRESH_1 : THRESH_2;
   wire logic [10:0] startAt  = (actStart == START_FULL || thresh > actLength) ?
                                actLength : thresh; // RULE_04
   wire logic [10:0] frameEnd = actLength > actPadTo ? actLength : actPadTo;
   wire logic        inData   = sendIdx < actLength;
   wire logic        byteAvl  = !inData || sendIdx < wrBytes;
   wire logic        canLoad  = !lineTx.valid || lineReady;
   wire logic        emit     = state == S_SEND && canLoad &&
                                sendIdx < frameEnd && byteAvl; // RULE_24
   wire logic [10:0] idxNext  = sendIdx + 11'd1;
   wire logic        lastByte = idxNext == frameEnd;
   wire logic        accept   = lineTx.valid && lineReady;
   wire logic        retry    = lineCollision &&
                                (state == S_SEND || state == S_RESULT);
   // frame writes count only while space is committed and not yet full
   wire logic        winWrite = wrWin && state != S_IDLE &&
                                wrBytes < actLength; // RULE_25
   wire logic [10:0] wrSum    = wrBytes + 11'd2;
   wire logic [10:0] wrNext   = wrSum > actLength ? actLength : wrSum;

   tx_frame_store u_store (
      .clk_sys     (clk_sys),
      .wrEn        (winWrite),
      .wrIndex     (wrBytes[10:1]),
      .wrData      (hostReq.wrData),
      .rdByteIndex (sendIdx),
      .rdByte      (storeByte)
   );

   always_comb
   begin
      next_state = state;
      case (state)
         S_IDLE:
            if (commit)
               next_state = S_FILL;
         S_FILL:
            if (wrBytes >= startAt)
               next_state = S_SEND; // RULE_04
         S_SEND:
            if (retry && actOneAttempt)
               next_state = S_IDLE; // RULE_06
            else if (!retry && accept && lineTx.last)
               next_state = S_RESULT;
         S_RESULT:
            if (retry)
               next_state = actOneAttempt ? S_IDLE : S_SEND; // RULE_06
            else if (lineOk || lineFail)
               next_state = S_IDLE;
         default:
            next_state = S_IDLE;
      endcase
      if (discard)
         next_state = S_IDLE; // RULE_05
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         state <= S_IDLE;
      else
         state <= next_state;
   end

   // host-visible registers
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         txCommand <= REG_RESET;
         transmit_configuration     <= REG_RESET;
         buffer_configuration    <= REG_RESET;
      end
      else
      begin
         if (wrCmd)
            txCommand <= hostReq.wrData; // RULE_03
         if (wrTxCfg)
            transmit_configuration <= hostReq.wrData;
         if (wrBufCf)
            buffer_configuration <= hostReq.wrData;
      end
   end

   // flags: a set in the clearing cycle wins, except that a command write clears readyNow even while readySet holds
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         reqPending <= 1'b0;
         cmdFresh   <= 1'b0;
         bidError   <= 1'b0;
         readyNow   <= 1'b0;
         bufReady   <= 1'b0;
         txOkFlag   <= 1'b0;
      end
      else
      begin
         reqPending <= !wrCmd && (lenOkWrite || (reqPending && !commit));
         cmdFresh   <= wrCmd || (cmdFresh && !wrLen);
         bidError   <= lenBadWrite || (bidError && !wrCmd); // RULE_13
         readyNow   <= !wrCmd && (readySet || (readyNow && !commit));
         bufReady   <= bufRdySet || (bufReady && !rdIsq); // RULE_16
         txOkFlag   <= okSet || (txOkFlag && !rdEvt); // RULE_20
      end
   end

   // bid capture and commit of the active frame
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         bidLength     <= 11'd0;
         bidPadTo      <= 11'd0;
         actLength     <= 11'd0;
         actPadTo      <= 11'd0;
         actStart      <= 2'h0;
         actNoCheck    <= 1'b0;
         actOneAttempt <= 1'b0;
      end
      else
      begin
         if (lenOkWrite)
         begin
            bidLength <= hostReq.wrData[10:0];
            bidPadTo  <= padTo;
         end
         if (commit)
         begin
            actLength     <= bidLength;
            actPadTo      <= bidPadTo;
            actStart      <= txCommand[CMD_START_LSB +: 2];
            actNoCheck    <= txCommand[CMD_NO_CHECK]; // RULE_07
            actOneAttempt <= txCommand[CMD_ONE_ATTEMPT];
         end
      end
   end

   // buffer fill and send counters
   always_ff @(posedge clk_sys)
   begin
      if (reset || commit || discard)
      begin
         wrBytes <= 11'd0;
         sendIdx <= 11'd0;
      end
      else
      begin
         if (winWrite)
            wrBytes <= wrNext;
         if (retry)
            sendIdx <= 11'd0;
         else if (emit)
            sendIdx <= idxNext;
      end
   end

   // line output: data, then pad zeros, check value flagged on last byte
   always_ff @(posedge clk_sys)
   begin
      if (reset || discard || retry)
         lineTx <= '0;
      else if (emit)
      begin
         lineTx.data        <= inData ? storeByte : 8'h00; // RULE_09 RULE_11
         lineTx.valid       <= 1'b1;
         lineTx.first       <= sendIdx == 11'd0;
         lineTx.last        <= lastByte;
         lineTx.appendCheck <= lastByte && !actNoCheck; // RULE_07
      end
      else if (accept)
         lineTx <= '0;
   end

   // read mux; unmapped and write-only offsets read zero
   wire logic [15:0] busWord = {7'h00, readyNow, bidError, 7'h00};
   wire logic [15:0] isqWord = {7'h00, bufReady, 8'h00};
   wire logic [15:0] evtWord = {7'h00, txOkFlag, 8'h00};
   wire logic [15:0] rdMux   = rdCmd ? txCommand :
                               rdBus ? busWord :
                               rdIsq ? isqWord :
                               rdEvt ? evtWord :
                               hostReq.addr == ADDR_TX_CFG ? transmit_configuration :
                               hostReq.addr == ADDR_BUF_CFG ? buffer_configuration : 16'h0000;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         hostRdData <= REG_RESET;
      else if (hostReq.read)
         hostRdData <= rdMux;
   end

   assign irqOut = (txOkFlag && transmit_configuration[CFG_TX_OK_IE]) ||
                   (bufReady && bufReadyIE); // RULE_20 RULE_16

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_cmd_readback: assert property ( // RULE_03
      wrCmd ##1 !hostReq.write ##1 rdCmd |=> hostRdData == $past(hostReq.wrData, 3))
      else $error("command readback differs from last write");
   a_bid_error: assert property ( // RULE_13
      lenBadWrite |=> bidError && !reqPending && !readyNow)
      else $error("bad length did not raise bid error");
   a_ready_now: assert property ( // RULE_14
      lenOkWrite && spaceFree |=> readyNow && reqPending)
      else $error("ready-now missing after good bid");
   a_idle_write: assert property ( // RULE_25
      wrWin && state == S_IDLE && !commit |=> $stable(wrBytes))
      else $error("frame write accepted without commit");
   a_start_wait: assert property ( // RULE_04
      state == S_FILL && wrBytes < startAt |=> state != S_SEND)
      else $error("preamble started before threshold");
   a_discard_all: assert property ( // RULE_05
      discard |=> state == S_IDLE && !lineTx.valid && wrBytes == 11'd0)
      else $error("discard left frame data");
   a_one_attempt: assert property ( // RULE_06
      retry && actOneAttempt && !discard |=> state == S_IDLE ##1 !lineTx.valid)
      else $error("retry after collision in single attempt");
   a_no_check: assert property ( // RULE_07
      lineTx.valid && lineTx.appendCheck |-> lineTx.last && !actNoCheck)
      else $error("check value flagged while inhibited");
   a_tx_ok: assert property ( // RULE_20
      okSet |=> txOkFlag && (irqOut || !transmit_configuration[CFG_TX_OK_IE]))
      else $error("success flag or interrupt missing");
   a_commit_cause: assert property ( // RULE_23
      state == S_IDLE ##1 state == S_FILL |-> $past(commit))
      else $error("space committed without ready read");

   c_poll_commit: cover property (rdBus && commit);
   c_isq_commit:  cover property (rdIsq && commit);
   c_retry:       cover property (retry && !actOneAttempt);
   c_success:     cover property (okSet);
endmodule
`default_nettype wire

// [verilog/eth_tx_pkg.sv]
// Purpose: shared constants and carriers for the transmit request logic
// Assumes: 16-bit registers at their memory-space offsets
// Notes:   offsets below 12'h120 hold the configuration and event registers
`default_nettype none
package eth_tx_pkg;
   localparam logic [11:0] ADDR_ISQ       = 12'h120;
   localparam logic [11:0] ADDR_BUS_STAT  = 12'h138;
   localparam logic [11:0] ADDR_TX_CMD    = 12'h144;
   localparam logic [11:0] ADDR_TX_LEN    = 12'h146;
   localparam logic [11:0] ADDR_FRAME_WIN = 12'hA00;
   localparam logic [11:0] ADDR_TX_CFG    = 12'h10E;
   localparam logic [11:0] ADDR_BUF_CFG   = 12'h116;
   localparam logic [11:0] ADDR_TX_EVENT  = 12'h110;
   localparam int CMD_START_LSB   = 6;
   localparam int CMD_DISCARD     = 8;
   localparam int CMD_ONE_ATTEMPT = 9;
   localparam int CMD_NO_CHECK    = 12;
   localparam int CMD_PAD_DIS     = 13;
   localparam int BUS_BID_ERR     = 7;
   localparam int BUS_READY_NOW   = 8;
   localparam int ISQ_BUF_READY   = 8;
   localparam int EVT_TX_OK       = 8;
   localparam int CFG_TX_OK_IE    = 8;
   localparam int BUF_READY_IE    = 8;
   localparam logic [15:0] REG_RESET  = 16'h0000;
   localparam logic [1:0]  START_FULL = 2'h3;
   localparam logic [10:0] THRESH_0   = 11'd5;
   localparam logic [10:0] THRESH_1   = 11'd381;
   localparam logic [10:0] THRESH_2   = 11'd1021;
   localparam logic [15:0] LEN_MIN          = 16'd3;
   localparam logic [15:0] LEN_MAX_CHECK    = 16'd1514;
   localparam logic [15:0] LEN_MAX_NO_CHECK = 16'd1518;
   localparam logic [10:0] LEN_PAD_TARGET   = 11'd60;
   localparam int BUF_WORDS = 759;
   typedef struct packed {
      logic [11:0] addr;
      logic [15:0] wrData;
      logic        write;
      logic        read;
   } hostReq_s;
   typedef struct packed {
      logic [7:0] data;
      logic       valid;
      logic       first;
      logic       last;
      logic       appendCheck;
   } lineTx_s;
   typedef enum logic [1:0] {
      S_IDLE   = 2'b00,
      S_FILL   = 2'b01,
      S_SEND   = 2'b10,
      S_RESULT = 2'b11
   } txState_e;
endpackage
`default_nettype wire

// [verilog/tx_frame_store.sv]
// Purpose: word-wide frame buffer with a byte-wide read side
// Assumes: first byte of a word sits in the low half
// Notes:   one frame deep; contents are never cleared, only counts
`default_nettype none
`timescale 1ns/100ps
module tx_frame_store (
   input  wire logic        clk_sys,
   input  wire logic        wrEn,
   input  wire logic [9:0]  wrIndex,
   input  wire logic [15:0] wrData,
   input  wire logic [10:0] rdByteIndex,
   output logic [7:0]       rdByte
);
   import eth_tx_pkg::*;
   logic [15:0] mem [0:BUF_WORDS-1];
   wire logic [15:0] rdWord = mem[rdByteIndex[10:1]];
   always_ff @(posedge clk_sys)
   begin
      if (wrEn)
         mem[wrIndex] <= wrData;
   end
   assign rdByte = rdByteIndex[0] ? rdWord[15:8] : rdWord[7:0];
endmodule
`default_nettype wire

// [verilog/tx_length_check.sv]
// Purpose: judge a bid length and work out the pad target
// Assumes: command bits are those current at the length write
// Notes:   purely combinational
`default_nettype none
`timescale 1ns/100ps
module tx_length_check (
   input  wire logic [15:0] length,
   input  wire logic        noCheck,
   input  wire logic        padDis,
   output logic             lengthOk,
   output logic [10:0]      padTo
);
   import eth_tx_pkg::*;
   // longer frames only fit when no check value is appended
   wire logic [15:0] maxLen = noCheck ? LEN_MAX_NO_CHECK : LEN_MAX_CHECK;
   assign lengthOk = (length >= LEN_MIN) && (length <= maxLen); // RULE_12 RULE_13
   // pad only when the check value is appended; pad disable alone still pads
   assign padTo = (!noCheck || !padDis) && !noCheck ? LEN_PAD_TARGET : 11'd0; // RULE_08 RULE_09 RULE_10 RULE_11 RULE_12
endmodule
`default_nettype wire
